// ---- pri_regs.svh ----
// Notes on behaviour
// [RL1] after supply reaches threshold, all macrocell registers clear low within 1000 ns
// [RL2] after the clear, each output level follows its buffer's programmed polarity
// [RL3] outside logic keeps the device clock pin still during the power-up interval
// [RL4] outside logic meets input and feedback setup before the first clock edge
// [RL5] test preload forces any chosen register individually high or low
// [RL6] 64-bit user signature stays readable, even when copy protection is on
// [RL7] copy-protection fuse blocks pattern readback and preload, effective at once
// [RL8] programmer should set the copy-protection fuse as its final step
// [RL9] undriven input and I/O pins keep their last driven level, weakly
// [RL10] one shared sync and one async reset term, both cleared at power-up
// [RL11] power-up reset holds registers low for a set count before release
`ifndef PRI_REGS_SVH
`define PRI_REGS_SVH

`define PRI_CLK_PERIOD_NS  20
`define PRI_POR_TIME_NS    1000
`define PRI_POR_CYC        (`PRI_POR_TIME_NS / `PRI_CLK_PERIOD_NS)

`define PRI_NUM_MC         10
`define PRI_NUM_IN         12

`define PRI_OFF_CTRL       8'h00
`define PRI_OFF_POL        8'h04
`define PRI_OFF_COMB       8'h08
`define PRI_OFF_TOG        8'h0c
`define PRI_OFF_AR         8'h10
`define PRI_OFF_SR         8'h14
`define PRI_OFF_PRELOAD    8'h18
`define PRI_OFF_STATUS     8'h1c
`define PRI_OFF_SIG_LO     8'h20
`define PRI_OFF_SIG_HI     8'h24

`define PRI_CTRL_SECURE    0
`define PRI_PL_VAL_LSB     0
`define PRI_PL_SEL_LSB     16
`define PRI_ST_Q_LSB       0
`define PRI_ST_PIN_LSB     10
`define PRI_ST_POR_DONE    20
`define PRI_ST_SECURED     21

`define PRI_SIG_RST        64'h0000_0000_0000_0000

`endif

// ---- pri_pkg.sv ----
package pri_pkg;

    typedef struct packed {
        logic [9:0]  pol;
        logic [9:0]  comb;
        logic [9:0]  tog;
        logic [11:0] ar_mask;
        logic [11:0] sr_mask;
    } pri_pattern_t;

    typedef enum logic [1:0] {
        PRI_POR_HOLD = 2'b01,
        PRI_POR_RUN  = 2'b10
    } pri_por_state_t;

endpackage : pri_pkg

// ---- pri_keeper.sv ----
`timescale 1ns/1ns
module pri_keeper #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] pad_i,
    input  wire logic [W-1:0] drv_i,
    output logic      [W-1:0] lvl_o
);

    logic [W-1:0] hold_reg;

    // a stronger driver always wins; the keeper only remembers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            hold_reg <= '0;
        end else begin
            hold_reg <= (drv_i & pad_i) | (~drv_i & hold_reg); // RL9
        end
    end

    assign lvl_o = (drv_i & pad_i) | (~drv_i & hold_reg); // RL9

    a_keeper_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ##1 (drv_i != {W{1'b1}}) |-> (((lvl_o ^ $past(lvl_o)) & ~drv_i) == '0)) // RL9
        else $error("undriven pin did not keep its level");

endmodule : pri_keeper

// ---- pri_core.sv ----
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "pri_regs.svh"
module pri_core
    import pri_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        pld_clk_i,
    input  wire logic [11:0] in_pad_i,
    input  wire logic [11:0] in_drv_i,
    input  wire logic [9:0]  io_pad_i,
    input  wire logic [9:0]  io_drv_i,
    output logic      [9:0]  io_o,
    output logic      [9:0]  io_oe_o
);

    pri_por_state_t por_state_reg;
    logic [7:0]     por_cnt_reg;
    logic           por_done;
    logic           secured_reg;
    pri_pattern_t   pat_reg;
    logic [63:0]    sig_reg;
    logic [9:0]     q_reg;
    logic [9:0]     io_out_reg;
    logic           io_en_reg;
    logic           pld_clk_reg;
    logic           clk_edge;
    logic [11:0]    in_lvl;
    logic [9:0]     io_lvl;
    logic [9:0]     d_vec;
    logic [9:0]     q_eff;
    logic [9:0]     out_src;
    logic           ar_term;
    logic           sr_term;
    logic           acc;
    logic           wr_acc;
    logic           pl_acc;
    logic           pl_refused;
    logic           mapped;
    logic           pready_reg;
    logic [31:0]    rdata_reg;
    logic           err_reg;
    logic [31:0]    rd_mux;
    logic           rd_err;

    // ---------------- power-up reset sequencer
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            por_state_reg <= PRI_POR_HOLD;
            por_cnt_reg   <= 8'h00;
        end else begin
            unique case (por_state_reg)
                PRI_POR_HOLD: begin
                    por_cnt_reg <= por_cnt_reg + 8'h01;
                    if (por_cnt_reg == 8'(`PRI_POR_CYC - 1)) begin // RL11
                        por_state_reg <= PRI_POR_RUN;
                    end
                end
                PRI_POR_RUN: begin
                    por_cnt_reg <= por_cnt_reg;
                end
                default: begin
                    por_state_reg <= PRI_POR_HOLD;
                    por_cnt_reg   <= 8'h00;
                end
            endcase
        end
    end

    assign por_done = (por_state_reg == PRI_POR_RUN);

    // ---------------- pin keepers
    pri_keeper #(.W(`PRI_NUM_IN)) u_in_keep (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .pad_i     (in_pad_i),
        .drv_i     (in_drv_i),
        .lvl_o     (in_lvl)
    );

    // our own drive counts as a driver so the keeper tracks what we put out
    pri_keeper #(.W(`PRI_NUM_MC)) u_io_keep (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .pad_i     ((io_oe_o & io_o) | (~io_oe_o & io_pad_i)),
        .drv_i     (io_oe_o | io_drv_i),
        .lvl_o     (io_lvl)
    );

    // ---------------- logic array
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            pld_clk_reg <= 1'b0;
        end else begin
            pld_clk_reg <= pld_clk_i;
        end
    end

    // edges during the power-up interval are dropped; the board can still pulse the pin then
    assign clk_edge = pld_clk_i & ~pld_clk_reg & por_done; // RL3

    // a mask of zero switches a term off; terms are dead until power-up ends
    assign ar_term = por_done & (|pat_reg.ar_mask)
                   & (&(in_lvl | ~pat_reg.ar_mask)); // RL10
    assign sr_term = por_done & (|pat_reg.sr_mask)
                   & (&(in_lvl | ~pat_reg.sr_mask)); // RL10

    assign d_vec   = in_lvl[9:0] ^ (pat_reg.tog & q_reg);
    assign q_eff   = q_reg & ~{10{ar_term}};
    assign out_src = (pat_reg.comb & d_vec) | (~pat_reg.comb & q_eff);

    assign acc        = psel_i & penable_i & pready_reg;
    assign wr_acc     = acc & pwrite_i;
    assign pl_acc     = wr_acc & (paddr_i == `PRI_OFF_PRELOAD) & ~secured_reg;
    assign pl_refused = wr_acc & (paddr_i == `PRI_OFF_PRELOAD) & secured_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || !por_done) begin
            q_reg <= '0; // RL1
        end else if (ar_term) begin
            q_reg <= '0; // RL10
        end else if (pl_acc) begin
            // preload overrides a coincident clock edge on all bits; unchosen bits keep their value
            q_reg <= (q_reg & ~pwdata_i[`PRI_PL_SEL_LSB +: 10])
                   | (pwdata_i[`PRI_PL_VAL_LSB +: 10]
                      & pwdata_i[`PRI_PL_SEL_LSB +: 10]); // RL5
        end else if (clk_edge) begin
            q_reg <= sr_term ? 10'h000 : d_vec; // RL10
        end
    end

    // polarity applies from the clear onward, so inverted pins come up high
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            io_out_reg <= '0;
            io_en_reg  <= 1'b0;
        end else begin
            io_out_reg <= out_src ^ pat_reg.pol; // RL2
            io_en_reg  <= por_done;
        end
    end

    assign io_o    = io_out_reg;
    assign io_oe_o = {10{io_en_reg}};

    // ---------------- register file
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            secured_reg <= 1'b0;
        end else if (wr_acc && paddr_i == `PRI_OFF_CTRL && pwdata_i[`PRI_CTRL_SECURE]) begin
            secured_reg <= 1'b1; // RL7
        end
    end

    // pattern stays writable; only verify and preload are locked out
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            pat_reg <= '0; // RL10
        end else if (wr_acc) begin
            unique case (paddr_i)
                `PRI_OFF_POL:  pat_reg.pol     <= pwdata_i[9:0];
                `PRI_OFF_COMB: pat_reg.comb    <= pwdata_i[9:0];
                `PRI_OFF_TOG:  pat_reg.tog     <= pwdata_i[9:0];
                `PRI_OFF_AR:   pat_reg.ar_mask <= pwdata_i[11:0];
                `PRI_OFF_SR:   pat_reg.sr_mask <= pwdata_i[11:0];
                default:       pat_reg         <= pat_reg;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            sig_reg <= `PRI_SIG_RST;
        end else if (wr_acc && paddr_i == `PRI_OFF_SIG_LO) begin
            sig_reg[31:0] <= pwdata_i; // RL6
        end else if (wr_acc && paddr_i == `PRI_OFF_SIG_HI) begin
            sig_reg[63:32] <= pwdata_i; // RL6
        end
    end

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr_i)
            `PRI_OFF_CTRL:    rd_mux = {31'h0, secured_reg};
            `PRI_OFF_POL:     rd_mux = secured_reg ? 32'h0 : {22'h0, pat_reg.pol};     // RL7
            `PRI_OFF_COMB:    rd_mux = secured_reg ? 32'h0 : {22'h0, pat_reg.comb};    // RL7
            `PRI_OFF_TOG:     rd_mux = secured_reg ? 32'h0 : {22'h0, pat_reg.tog};     // RL7
            `PRI_OFF_AR:      rd_mux = secured_reg ? 32'h0 : {20'h0, pat_reg.ar_mask}; // RL7
            `PRI_OFF_SR:      rd_mux = secured_reg ? 32'h0 : {20'h0, pat_reg.sr_mask}; // RL7
            `PRI_OFF_PRELOAD: rd_mux = 32'h0;
            `PRI_OFF_STATUS:  rd_mux = {10'h0, secured_reg, por_done, io_lvl, q_eff};
            `PRI_OFF_SIG_LO:  rd_mux = sig_reg[31:0];  // RL6
            `PRI_OFF_SIG_HI:  rd_mux = sig_reg[63:32]; // RL6
            default:          mapped = 1'b0;
        endcase
        rd_err = ~mapped;
    end

    // one wait state so read data and the error flag come from flip-flops
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            pready_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            err_reg    <= 1'b0;
        end else if (psel_i && penable_i && !pready_reg) begin
            pready_reg <= 1'b1;
            rdata_reg  <= pwrite_i ? 32'h0000_0000 : rd_mux;
            err_reg    <= rd_err | (pwrite_i & (paddr_i == `PRI_OFF_PRELOAD) & secured_reg);
        end else begin
            pready_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            err_reg    <= 1'b0;
        end
    end

    assign pready_o  = pready_reg;
    assign prdata_o  = rdata_reg;
    assign pslverr_o = err_reg;

    // ---------------- checks
    sequence s_pat_read_setup;
        psel_i && !penable_i && !pwrite_i && secured_reg
        && (paddr_i inside {`PRI_OFF_POL, `PRI_OFF_COMB, `PRI_OFF_TOG,
                            `PRI_OFF_AR, `PRI_OFF_SR});
    endsequence

    sequence s_sig_read_setup;
        psel_i && !penable_i && !pwrite_i && secured_reg
        && (paddr_i == `PRI_OFF_SIG_LO);
    endsequence

    a_por_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !por_done |=> (q_reg == 10'h000)) // RL1
        else $error("register not low during power-up");

    a_por_length: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(por_done) |-> (por_cnt_reg == 8'(`PRI_POR_CYC))) // RL11
        else $error("power-up interval has wrong length");

    a_por_max: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (por_cnt_reg <= 8'(`PRI_POR_CYC))) // RL1
        else $error("power-up count overran");

    a_out_polarity: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ##1 (io_o == $past(out_src ^ pat_reg.pol))) // RL2
        else $error("output does not follow buffer polarity");

    a_edge_ignored: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (pld_clk_i && !pld_clk_reg && !por_done) |=> (q_reg == 10'h000)) // RL3
        else $error("clock edge acted during power-up");

    a_preload_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (pl_acc && !ar_term) |=> ((q_reg & $past(pwdata_i[25:16]))
                                 == ($past(pwdata_i[9:0]) & $past(pwdata_i[25:16])))) // RL5
        else $error("preload did not force the chosen bits");

    a_sig_read: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_sig_read_setup ##1 (psel_i && penable_i) |=>
            (pready_o && !pslverr_o && prdata_o == sig_reg[31:0])) // RL6
        else $error("signature unreadable while secured");

    a_pat_hidden: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_pat_read_setup ##1 (psel_i && penable_i) |=> (pready_o && prdata_o == 32'h0)) // RL7
        else $error("pattern readable while secured");

    a_pl_refused: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (secured_reg && psel_i && penable_i && !pready_reg && pwrite_i
         && paddr_i == `PRI_OFF_PRELOAD) |=> (pslverr_o && !pl_acc)) // RL7
        else $error("preload not refused while secured");

    a_terms_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !por_done |-> (!ar_term && !sr_term)) // RL10
        else $error("reset term active during power-up");

    a_async_term: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ar_term |-> (q_eff == 10'h000) ##1 (q_reg == 10'h000)) // RL10
        else $error("async term did not clear registers");

endmodule : pri_core

// ---- pri_board.sv ----
`timescale 1ns/1ns
module pri_board (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        arm_i,
    input  wire logic        go_i,
    input  wire logic [11:0] val_i,
    input  wire logic [11:0] flt_i,
    output logic             pld_clk_o,
    output logic      [11:0] in_pad_o,
    output logic      [11:0] in_drv_o,
    output logic             busy_o
);
    logic [1:0] st_reg;

    assign busy_o = (st_reg != 2'h0);

    // released lines toggle every cycle except the one a pulse starts in, so a missing keeper cannot pass by luck
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            st_reg    <= 2'h0;
            pld_clk_o <= 1'b0;
            in_pad_o  <= 12'h000;
            in_drv_o  <= 12'hfff;
        end else begin
            in_pad_o <= in_pad_o ^ ~in_drv_o;
            case (st_reg)
                2'h0: if (go_i && arm_i) begin
                    st_reg   <= 2'h1;
                    in_pad_o <= (val_i & ~flt_i) | (in_pad_o & flt_i);
                    in_drv_o <= ~flt_i;
                end
                2'h1: begin
                    pld_clk_o <= 1'b1;
                    st_reg    <= 2'h2;
                end
                2'h2: begin
                    pld_clk_o <= 1'b0;
                    st_reg    <= 2'h3;
                end
                default: st_reg <= 2'h0;
            endcase
        end
    end
endmodule : pri_board

// ---- pri_core_test.sv ----
`timescale 1ns/1ns
`include "pri_regs.svh"
module pri_core_test;
    localparam logic [9:0] POL = 10'h2a5;
    logic        ref_clk = 1'b0;
    logic        rst_b   = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0;
    logic [9:0]  io_pad  = 10'h000;
    logic [9:0]  io_drv  = 10'h3ff;
    logic        arm     = 1'b0;
    logic        go      = 1'b0;
    logic [11:0] val     = 12'h000;
    logic [11:0] flt     = 12'h000;
    logic [31:0] prdata, rd, pw;
    logic        pready, pslverr, pld_clk, busy, er;
    logic [11:0] in_pad, in_drv;
    logic [9:0]  io_o, io_oe, exp_q;
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          j;

    always #10 ref_clk = ~ref_clk;

    pri_core i_dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pld_clk_i(pld_clk), .in_pad_i(in_pad),
        .in_drv_i(in_drv), .io_pad_i(io_pad), .io_drv_i(io_drv), .io_o(io_o),
        .io_oe_o(io_oe));

    pri_board i_board (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .arm_i(arm), .go_i(go),
        .val_i(val), .flt_i(flt), .pld_clk_o(pld_clk), .in_pad_o(in_pad),
        .in_drv_o(in_drv), .busy_o(busy));

    task summarize();
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one transfer; returns right after an idle edge so calls never collide
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge ref_clk);
        end
        if (n == 20) chk(32'h0, 32'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task pulse(input logic [11:0] v, input logic [11:0] f);
        int n;
        n = 0;
        val <= v;
        flt <= f;
        go  <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        while (busy === 1'b1 && n < 20) begin
            n++;
            @(posedge ref_clk);
        end
        repeat (2) @(posedge ref_clk);
        apb(1'b0, `PRI_OFF_STATUS, 32'h0);
    endtask : pulse

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            $display("mismatch at %0t: run too long", $time);
            summarize();
        end
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, `PRI_OFF_STATUS, 32'h0);
        chk(rd[`PRI_ST_POR_DONE], 1'b0);
        chk(rd[9:0], 10'h000);
        chk(io_oe, 10'h000);
        // a clock edge during power-up must be dropped
        arm <= 1'b1;
        pulse(12'h3ff, 12'h000);
        chk(rd[9:0], 10'h000);
        arm <= 1'b0;
        apb(1'b1, `PRI_OFF_POL, {22'h0, POL});
        apb(1'b0, `PRI_OFF_AR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `PRI_OFF_SR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `PRI_OFF_SIG_LO, 32'h0);
        chk(rd, `PRI_SIG_RST);
        repeat (30) @(posedge ref_clk);
        apb(1'b0, `PRI_OFF_STATUS, 32'h0);
        chk(rd[`PRI_ST_POR_DONE], 1'b1);
        chk(rd[9:0], 10'h000);
        chk(io_o, POL);
        chk(io_oe, 10'h3ff);
        apb(1'b0, `PRI_OFF_POL, 32'h0);
        chk(rd[9:0], POL);
        arm   <= 1'b1;
        exp_q = 10'h000;
        // set each register alone, then clear each alone
        for (int i = 0; i < 20; i++) begin
            j = i % 10;
            exp_q[j] = (i < 10);
            pw = 32'h0;
            pw[`PRI_PL_SEL_LSB + j] = 1'b1;
            pw[9:0] = (i < 10) ? 10'h3ff : 10'h000;
            apb(1'b1, `PRI_OFF_PRELOAD, pw);
            apb(1'b0, `PRI_OFF_STATUS, 32'h0);
            chk(rd[9:0], exp_q);
            chk(io_o, exp_q ^ POL);
        end
        pulse(12'h15a, 12'h000);
        chk(rd[9:0], 10'h15a);
        apb(1'b1, `PRI_OFF_TOG, 32'h3ff);
        pulse(12'h0ff, 12'h000);
        chk(rd[9:0], 10'h1a5);
        apb(1'b1, `PRI_OFF_TOG, 32'h0);
        apb(1'b1, `PRI_OFF_SR, 32'h800);
        pulse(12'h8ff, 12'h000);
        chk(rd[9:0], 10'h000);
        pulse(12'h3ff, 12'h000);
        chk(rd[9:0], 10'h3ff);
        apb(1'b1, `PRI_OFF_SR, 32'h0);
        apb(1'b1, `PRI_OFF_AR, 32'h400);
        pulse(12'h4ff, 12'h000);
        apb(1'b1, `PRI_OFF_PRELOAD, 32'h03ff_03ff);
        apb(1'b0, `PRI_OFF_STATUS, 32'h0);
        chk(rd[9:0], 10'h000);
        apb(1'b1, `PRI_OFF_AR, 32'h0);
        pulse(12'h2aa, 12'h000);
        pulse(12'h155, 12'h3ff);
        chk(rd[9:0], 10'h2aa);
        io_pad <= 10'h155;
        repeat (2) @(posedge ref_clk);
        io_drv <= 10'h000;
        io_pad <= 10'h2aa;
        repeat (3) @(posedge ref_clk);
        apb(1'b0, `PRI_OFF_STATUS, 32'h0);
        // our own drive outranks the board's level on the pins
        chk(rd[19:10], 10'h2aa ^ POL);
        apb(1'b1, `PRI_OFF_SIG_LO, 32'h89ab_cdef);
        apb(1'b1, `PRI_OFF_SIG_HI, 32'h0123_4567);
        // protection goes on last, as its effect is immediate
        apb(1'b1, `PRI_OFF_CTRL, 32'h1);
        apb(1'b0, `PRI_OFF_STATUS, 32'h0);
        chk(rd[`PRI_ST_SECURED], 1'b1);
        apb(1'b0, `PRI_OFF_POL, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b0);
        apb(1'b1, `PRI_OFF_PRELOAD, 32'h03ff_0000);
        chk(er, 1'b1);
        apb(1'b0, `PRI_OFF_STATUS, 32'h0);
        chk(rd[9:0], 10'h2aa);
        apb(1'b0, `PRI_OFF_SIG_LO, 32'h0);
        chk(rd, 32'h89ab_cdef);
        apb(1'b1, `PRI_OFF_SIG_HI, 32'hfedc_ba98);
        apb(1'b0, `PRI_OFF_SIG_HI, 32'h0);
        chk(rd, 32'hfedc_ba98);
        apb(1'b0, 8'h28, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        summarize();
    end
endmodule : pri_core_test
